// ---- design/scs_cfg.svh ----
// Purpose: constants of the sample clock source select block
// Assumes: word registers on APB, byte address is four times the index
// Notes: frequencies in hertz
`ifndef SCS_CFG_SVH
`define SCS_CFG_SVH

`define SCS_IDX_RATE 16'h4e20
`define SCS_IDX_CLKOUT 16'h4e8e
`define SCS_IDX_CLKFREQ 16'h4e8f
`define SCS_IDX_TERM 16'h4e98
`define SCS_IDX_REF 16'h4eac
`define SCS_IDX_MODE 16'h4ee8
`define SCS_ADDR_RATE ({`SCS_IDX_RATE, 2'b00})
`define SCS_ADDR_CLKOUT ({`SCS_IDX_CLKOUT, 2'b00})
`define SCS_ADDR_CLKFREQ ({`SCS_IDX_CLKFREQ, 2'b00})
`define SCS_ADDR_TERM ({`SCS_IDX_TERM, 2'b00})
`define SCS_ADDR_REF ({`SCS_IDX_REF, 2'b00})
`define SCS_ADDR_MODE ({`SCS_IDX_MODE, 2'b00})

`define SCS_MIN_RATE_HZ 32'h0000_03e8
`define SCS_REF_MIN_HZ 32'h000f_4240
`define SCS_REF_MAX_HZ 32'h0773_5940
`define SCS_REF_RESET_HZ 32'h0098_9680
`define SCS_OSC1_DEF_HZ 32'h05f5_e100
`define SCS_OSC2_DEF_HZ 32'h02fa_f080
`define SCS_DIV_MAX 32'h0000_ffff
`define SCS_PLL_POST 32'h0000_0100
`define SCS_PLL_NMAX 32'h0000_03ff
`define SCS_DIV_STEPS 6'h30

`endif

// ---- design/scs_pkg.sv ----
// Purpose: types of the sample clock source select block
// Assumes: nothing beyond the constants header
// Notes: mode codes equal the values software writes
`default_nettype none
package scs_pkg;

  typedef enum logic [5:0] {
    SCS_MODE_OSC1 = 6'h02,
    SCS_MODE_OSC2 = 6'h04,
    SCS_MODE_PLL_EXT = 6'h20
  } scs_mode_t;

  typedef enum logic [1:0] {
    SCS_CALC_IDLE = 2'b00,
    SCS_CALC_STEP1 = 2'b01,
    SCS_CALC_STEP2 = 2'b10,
    SCS_CALC_DONE = 2'b11
  } scs_calc_t;

  typedef struct packed {
    scs_mode_t src;
    logic pll_bypass;
    logic pll_ref_ext;
    logic [15:0] divider;
    logic [9:0] pll_mult;
  } scs_clk_ctrl_t;

endpackage : scs_pkg
`default_nettype wire

// ---- design/scs_divu.sv ----
// Purpose: iterative unsigned divider, one quotient bit per clock
// Assumes: den is never zero at start
// Notes: 48 steps; done pulses one cycle with quo valid
`timescale 1ns/1ps
`default_nettype none
`include "scs_cfg.svh"

module scs_divu
  import scs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [47:0] num,
  input wire logic [31:0] den,
  output logic done,
  output logic [47:0] quo
);

  logic [5:0] cnt_q;
  logic [47:0] quo_q;
  logic [32:0] rem_q;
  logic [31:0] den_q;
  logic done_q;
  logic [32:0] shifted;
  logic [32:0] trial;

  assign shifted = {rem_q[31:0], quo_q[47]};
  assign trial = shifted - {1'b0, den_q};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 6'h00;
      quo_q <= 48'h0;
      rem_q <= 33'h0;
      den_q <= 32'h0;
    end else if (start) begin
      cnt_q <= `SCS_DIV_STEPS;
      quo_q <= num;
      rem_q <= 33'h0;
      den_q <= den;
    end else if (cnt_q != 6'h00) begin
      cnt_q <= cnt_q - 6'h01;
      if (!trial[32]) begin
        rem_q <= trial;
        quo_q <= {quo_q[46:0], 1'b1};
      end else begin
        rem_q <= shifted;
        quo_q <= {quo_q[46:0], 1'b0};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b0;
    end else begin
      done_q <= (cnt_q == 6'h01) && !start;
    end
  end

  assign done = done_q;
  assign quo = quo_q;

endmodule : scs_divu
`default_nettype wire

// ---- design/scs_top.sv ----
// Purpose: sample clock source selection and setup, APB register slave
// Assumes: APB master on pclk; fitted strap is asynchronous
// Notes: rate writes and accepted mode writes stall pready while dividers run
`timescale 1ns/1ps
`default_nettype none
`include "scs_cfg.svh"

module scs_top
  import scs_pkg::*;
#(
  parameter logic [31:0] OSC1_HZ = `SCS_OSC1_DEF_HZ,
  parameter logic [31:0] OSC2_HZ = `SCS_OSC2_DEF_HZ
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic second_osc_fitted,
  output scs_clk_ctrl_t clk_ctrl,
  output logic clock_out_drive,
  output logic term_50_on
);

  function automatic logic [31:0] f_clamp(input logic [31:0] v,
                                          input logic [31:0] lo,
                                          input logic [31:0] hi);
    f_clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : f_clamp

  function automatic logic f_is_osc(input scs_mode_t m);
    f_is_osc = (m == SCS_MODE_OSC1) || (m == SCS_MODE_OSC2);
  endfunction : f_is_osc

  logic fit_s1_q;
  logic fit_s2_q;
  scs_mode_t mode_q;
  logic [31:0] rate_req_q;
  logic [31:0] rate_act_q;
  logic [15:0] div_q;
  logic [9:0] mult_q;
  logic [31:0] ref_q;
  logic clk_out_en_q;
  logic term_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  scs_calc_t calc_q;
  scs_mode_t c_mode_q;
  logic [31:0] c_req_q;
  logic [15:0] c_div_q;
  logic [9:0] c_mult_q;
  logic [31:0] c_act_q;
  scs_clk_ctrl_t clk_ctrl_q;
  logic clock_out_drive_q;
  logic term_50_on_q;

  logic access;
  logic xfer;
  logic hit_rate;
  logic hit_mode;
  logic hit_clkout;
  logic hit_freq;
  logic hit_term;
  logic hit_ref;
  logic mode_ok;
  logic ref_ok;
  logic needs_calc;
  logic go;
  scs_mode_t st_mode;
  logic [31:0] st_req;
  logic [31:0] st_osc;
  logic [31:0] c_osc;
  logic div_start;
  logic [47:0] div_num;
  logic [31:0] div_den;
  logic div_done;
  logic [47:0] div_quo;
  logic [31:0] q_sat;
  logic [31:0] d_pick;
  logic [31:0] n_pick;
  logic [32:0] d_low;
  logic [15:0] div_sel;
  logic bad_wr;
  logic [31:0] rd_val;

  assign access = psel && penable;
  assign xfer = access && pready_q;
  assign hit_rate = (paddr == `SCS_ADDR_RATE);
  assign hit_mode = (paddr == `SCS_ADDR_MODE);
  assign hit_clkout = (paddr == `SCS_ADDR_CLKOUT);
  assign hit_freq = (paddr == `SCS_ADDR_CLKFREQ);
  assign hit_term = (paddr == `SCS_ADDR_TERM);
  assign hit_ref = (paddr == `SCS_ADDR_REF);
  // absent second oscillator refused
  assign mode_ok = (pwdata == 32'h0000_0002) ||
                   ((pwdata == 32'h0000_0004) && fit_s2_q) ||
                   (pwdata == 32'h0000_0020);
  assign ref_ok = (pwdata >= `SCS_REF_MIN_HZ) &&
                  (pwdata <= `SCS_REF_MAX_HZ);
  assign needs_calc = pwrite && (hit_rate || (hit_mode && mode_ok));
  assign go = access && !pready_q && (calc_q == SCS_CALC_IDLE) &&
              needs_calc;

  // mode write recomputes with the stored request
  assign st_mode = hit_mode ? scs_mode_t'(pwdata[5:0]) : mode_q;
  assign st_req = f_clamp(hit_rate ? pwdata : rate_req_q,
                          `SCS_MIN_RATE_HZ, OSC1_HZ);
  assign st_osc = (st_mode == SCS_MODE_OSC2) ? OSC2_HZ : OSC1_HZ;
  assign c_osc = (c_mode_q == SCS_MODE_OSC2) ? OSC2_HZ : OSC1_HZ;

  // rounded quotient saturated to the setting range
  assign q_sat = (div_quo[47:32] != 16'h0) ? 32'hffff_ffff : div_quo[31:0];
  assign d_pick = f_clamp(q_sat, 32'h0000_0001, `SCS_DIV_MAX);
  assign n_pick = f_clamp(q_sat, 32'h0000_0001, `SCS_PLL_NMAX);
  // divider too large would fall under the minimum rate
  assign d_low = {1'b0, d_pick} * 33'd1000;
  assign div_sel = (d_low > {1'b0, c_osc} && d_pick != 32'h0000_0001) ?
                   d_pick[15:0] - 16'h0001 : d_pick[15:0];

  always_comb begin
    div_start = 1'b0;
    div_num = 48'h0;
    div_den = 32'h0000_0001;
    if (go) begin
      div_start = 1'b1;
      if (f_is_osc(st_mode)) begin
        div_num = {16'h0, st_osc} + {17'h0, st_req[31:1]};
        div_den = st_req;
      end else begin
        div_num = ({16'h0, st_req} << 8) + {17'h0, ref_q[31:1]};
        div_den = ref_q;
      end
    end else if ((calc_q == SCS_CALC_STEP1) && div_done) begin
      div_start = 1'b1;
      // second pass uses the setting picked this cycle
      if (f_is_osc(c_mode_q)) begin
        div_num = {16'h0, c_osc} + {33'h0, div_sel[15:1]};
        div_den = {16'h0, div_sel};
      end else begin
        div_num = {16'h0, ref_q} * {38'h0, n_pick[9:0]} +
                  {16'h0, `SCS_PLL_POST >> 1};
        div_den = `SCS_PLL_POST;
      end
    end
  end

  scs_divu u_divu (
    .pclk(pclk),
    .presetn(presetn),
    .start(div_start),
    .num(div_num),
    .den(div_den),
    .done(div_done),
    .quo(div_quo)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fit_s1_q <= 1'b0;
      fit_s2_q <= 1'b0;
    end else begin
      fit_s1_q <= second_osc_fitted;
      fit_s2_q <= fit_s1_q;
    end
  end

  // setting search: step1 finds divider or PLL multiplier, step2 the achieved rate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      calc_q <= SCS_CALC_IDLE;
      c_mode_q <= SCS_MODE_OSC1;
      c_req_q <= 32'h0;
      c_div_q <= 16'h0001;
      c_mult_q <= 10'h001;
      c_act_q <= 32'h0;
    end else begin
      case (calc_q)
        SCS_CALC_IDLE: begin
          if (go) begin
            calc_q <= SCS_CALC_STEP1;
            c_mode_q <= st_mode;
            c_req_q <= hit_rate ? pwdata : rate_req_q;
          end
        end
        SCS_CALC_STEP1: begin
          if (div_done) begin
            calc_q <= SCS_CALC_STEP2;
            c_div_q <= div_sel;
            c_mult_q <= n_pick[9:0];
          end
        end
        SCS_CALC_STEP2: begin
          if (div_done) begin
            calc_q <= SCS_CALC_DONE;
            c_act_q <= q_sat;
          end
        end
        SCS_CALC_DONE: begin
          calc_q <= SCS_CALC_IDLE;
        end
        default: begin
          calc_q <= SCS_CALC_IDLE;
        end
      endcase
    end
  end

  assign bad_wr = (hit_mode && !mode_ok) || (hit_ref && !ref_ok) ||
                  hit_freq ||
                  (hit_clkout && pwdata[0] && !f_is_osc(mode_q));

  always_comb begin
    rd_val = 32'h0;
    if (hit_mode) begin
      rd_val = {26'h0, mode_q};
    end else if (hit_rate) begin
      rd_val = rate_act_q;
    end else if (hit_clkout) begin
      rd_val = {31'h0, clk_out_en_q};
    end else if (hit_freq) begin
      rd_val = clock_out_drive_q ? rate_act_q : 32'h0;
    end else if (hit_term) begin
      rd_val = {31'h0, term_q};
    end else if (hit_ref) begin
      rd_val = ref_q;
    end
  end

  // answer: one wait state, or when the setting search ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else if (xfer) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else if (calc_q == SCS_CALC_DONE) begin
      pready_q <= 1'b1;
      pslverr_q <= 1'b0;
    end else if (access && !needs_calc && calc_q == SCS_CALC_IDLE) begin
      pready_q <= 1'b1;
      prdata_q <= pwrite ? 32'h0 : rd_val;
      pslverr_q <= pwrite ? (bad_wr || !(hit_mode || hit_rate || hit_ref ||
                   hit_clkout || hit_term)) :
                   !(hit_mode || hit_rate || hit_ref || hit_clkout ||
                   hit_term || hit_freq);
    end
  end

  // registers change only at the completing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= SCS_MODE_OSC1;
      rate_req_q <= OSC1_HZ;
      rate_act_q <= OSC1_HZ;
      div_q <= 16'h0001;
      mult_q <= 10'h001;
    end else if (xfer && pwrite && needs_calc) begin
      mode_q <= c_mode_q;
      rate_req_q <= c_req_q;
      rate_act_q <= c_act_q;
      div_q <= c_div_q;
      mult_q <= c_mult_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_q <= `SCS_REF_RESET_HZ;
      clk_out_en_q <= 1'b0;
      term_q <= 1'b0;
    end else if (xfer && pwrite && !pslverr_q) begin
      if (hit_ref) begin
        ref_q <= pwdata;
      end
      if (hit_clkout) begin
        clk_out_en_q <= pwdata[0];
      end
      if (hit_term) begin
        term_q <= pwdata[0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_ctrl_q <= '{SCS_MODE_OSC1, 1'b1, 1'b0, 16'h0001, 10'h001};
      clock_out_drive_q <= 1'b0;
      term_50_on_q <= 1'b0;
    end else begin
      clk_ctrl_q.src <= mode_q;
      clk_ctrl_q.pll_bypass <= f_is_osc(mode_q);
      clk_ctrl_q.pll_ref_ext <= (mode_q == SCS_MODE_PLL_EXT);
      clk_ctrl_q.divider <= div_q;
      clk_ctrl_q.pll_mult <= mult_q;
      clock_out_drive_q <= clk_out_en_q && f_is_osc(mode_q);
      term_50_on_q <= term_q && (mode_q == SCS_MODE_PLL_EXT);
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign clk_ctrl = clk_ctrl_q;
  assign clock_out_drive = clock_out_drive_q;
  assign term_50_on = term_50_on_q;

  property p_bad_mode;
    @(posedge pclk) disable iff (!presetn)
    xfer && pwrite && hit_mode && !mode_ok |-> pslverr_q ##1 $stable(mode_q);
  endproperty
  a_bad_mode: assert property (p_bad_mode)
    else $error("bad mode taken");

  property p_osc_bypass;
    @(posedge pclk) disable iff (!presetn)
    f_is_osc(mode_q) |=>
      clk_ctrl_q.pll_bypass && clk_ctrl_q.src == $past(mode_q);
  endproperty
  a_osc_bypass: assert property (p_osc_bypass)
    else $error("pll not bypassed");

  property p_pll_ext;
    @(posedge pclk) disable iff (!presetn)
    mode_q == SCS_MODE_PLL_EXT |=>
      clk_ctrl_q.pll_ref_ext && !clk_ctrl_q.pll_bypass;
  endproperty
  a_pll_ext: assert property (p_pll_ext)
    else $error("pll ref not external");

  property p_clkout;
    @(posedge pclk) disable iff (!presetn)
    clock_out_drive_q |->
      $past(clk_out_en_q) && $past(mode_q) != SCS_MODE_PLL_EXT;
  endproperty
  a_clkout: assert property (p_clkout)
    else $error("clock out not internal");

  property p_term_on;
    @(posedge pclk) disable iff (!presetn)
    term_q && mode_q == SCS_MODE_PLL_EXT |=> term_50_on_q;
  endproperty
  a_term_on: assert property (p_term_on)
    else $error("termination missing");

  property p_term_off;
    @(posedge pclk) disable iff (!presetn)
    mode_q != SCS_MODE_PLL_EXT |=> !term_50_on_q;
  endproperty
  a_term_off: assert property (p_term_off)
    else $error("termination as output");

  property p_min_rate;
    @(posedge pclk) disable iff (!presetn)
    xfer && pwrite && hit_rate |=> rate_act_q >= `SCS_MIN_RATE_HZ;
  endproperty
  a_min_rate: assert property (p_min_rate)
    else $error("rate under minimum");

  property p_ref_rej;
    @(posedge pclk) disable iff (!presetn)
    xfer && pwrite && hit_ref && !ref_ok |-> pslverr_q ##1 $stable(ref_q);
  endproperty
  a_ref_rej: assert property (p_ref_rej)
    else $error("bad reference taken");

  property p_calc_time;
    @(posedge pclk) disable iff (!presetn)
    go |-> ##[100:103] pready_q;
  endproperty
  a_calc_time: assert property (p_calc_time)
    else $error("rate answer late");

endmodule : scs_top
`default_nettype wire

// ---- tb/scs_host_model.sv ----
// Purpose: host side APB master standing for the board driver
// Assumes: one transfer at a time, launched after a rising edge
// Notes: ordering duties of software are kept by the callers
`timescale 1ns/1ps
`default_nettype none

module scs_host_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [17:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 18'h00000;
    pwdata = 32'h0000_0000;
  end

  // request held until pready is seen high at an edge
  task automatic xfer(input logic wr, input logic [17:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : scs_host_model

`default_nettype wire

// ---- tb/tb_top.sv ----
// Purpose: self-checking bench of the sample clock source select block
// Assumes: default oscillator parameters, 100 MHz and 50 MHz
// Notes: expected rates worked out by hand from the rounding choices
`timescale 1ns/1ps
`default_nettype none
`include "scs_cfg.svh"

module tb_top;
  import scs_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fitted;
  logic clock_out_drive, term_50_on;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata;
  scs_clk_ctrl_t clk_ctrl;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;

  scs_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .second_osc_fitted(fitted), .clk_ctrl(clk_ctrl),
    .clock_out_drive(clock_out_drive), .term_50_on(term_50_on));

  scs_host_model host_u (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic report_and_stop;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  // hang guard, far above the expected run
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 8000) begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [17:0] a, input logic [31:0] d,
                    input logic eerr);
    logic [31:0] r;
    logic e;
    host_u.xfer(1'b1, a, d, r, e);
    chk({31'h0, e}, {31'h0, eerr});
  endtask : wr

  task automatic rd(input logic [17:0] a, input logic [31:0] exp,
                    input logic eerr);
    logic [31:0] r;
    logic e;
    host_u.xfer(1'b0, a, 32'h0, r, e);
    chk({31'h0, e}, {31'h0, eerr});
    chk(r, exp);
  endtask : rd

  // let registered outputs land before looking
  task automatic settle;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
  endtask : settle

  task automatic t_reset;
    rd(`SCS_ADDR_MODE, 32'h0000_0002, 1'b0);
    rd(`SCS_ADDR_REF, 32'h0098_9680, 1'b0);
    rd(`SCS_ADDR_RATE, 32'h05f5_e100, 1'b0);
    rd(`SCS_ADDR_CLKOUT, 32'h0, 1'b0);
    rd(`SCS_ADDR_TERM, 32'h0, 1'b0);
    rd(`SCS_ADDR_CLKFREQ, 32'h0, 1'b0);
    rd(18'h00100, 32'h0, 1'b1);
    chk(32'(clk_ctrl.pll_bypass), 32'h1);
  endtask : t_reset

  task automatic t_osc1;
    wr(`SCS_ADDR_RATE, 32'd3000000, 1'b0);
    rd(`SCS_ADDR_RATE, 32'd3030303, 1'b0);
    settle();
    chk(32'(clk_ctrl.divider), 32'd33);
    chk(32'(clk_ctrl.src), 32'(SCS_MODE_OSC1));
    wr(`SCS_ADDR_RATE, 32'd500, 1'b0);
    rd(`SCS_ADDR_RATE, 32'd1526, 1'b0);
    settle();
    chk(32'(clk_ctrl.divider), 32'd65535);
  endtask : t_osc1

  task automatic t_clkout;
    wr(`SCS_ADDR_RATE, 32'd3000000, 1'b0);
    wr(`SCS_ADDR_CLKOUT, 32'h1, 1'b0);
    settle();
    chk(32'(clock_out_drive), 32'h1);
    rd(`SCS_ADDR_CLKFREQ, 32'd3030303, 1'b0);
    wr(`SCS_ADDR_CLKFREQ, 32'h5, 1'b1);
    rd(`SCS_ADDR_CLKFREQ, 32'd3030303, 1'b0);
  endtask : t_clkout

  task automatic t_osc2;
    wr(`SCS_ADDR_MODE, 32'h4, 1'b1);
    wr(`SCS_ADDR_MODE, 32'h7, 1'b1);
    rd(`SCS_ADDR_MODE, 32'h2, 1'b0);
    fitted <= 1'b1;
    repeat (3) @(posedge pclk);
    wr(`SCS_ADDR_MODE, 32'h4, 1'b0);
    wr(`SCS_ADDR_RATE, 32'd50000000, 1'b0);
    rd(`SCS_ADDR_RATE, 32'd50000000, 1'b0);
    settle();
    chk(32'(clk_ctrl.divider), 32'd1);
    chk(32'(clk_ctrl.src), 32'(SCS_MODE_OSC2));
    wr(`SCS_ADDR_RATE, 32'd12500000, 1'b0);
    rd(`SCS_ADDR_RATE, 32'd12500000, 1'b0);
    settle();
    chk(32'(clk_ctrl.divider), 32'd4);
    chk(32'(clock_out_drive), 32'h1);
    rd(`SCS_ADDR_CLKFREQ, 32'd12500000, 1'b0);
  endtask : t_osc2

  task automatic t_pll;
    wr(`SCS_ADDR_MODE, 32'h20, 1'b0);
    rd(`SCS_ADDR_MODE, 32'h20, 1'b0);
    settle();
    chk(32'(clock_out_drive), 32'h0);
    rd(`SCS_ADDR_CLKFREQ, 32'h0, 1'b0);
    wr(`SCS_ADDR_CLKOUT, 32'h1, 1'b1);
    wr(`SCS_ADDR_REF, 32'd999999, 1'b1);
    wr(`SCS_ADDR_REF, 32'd125000001, 1'b1);
    wr(`SCS_ADDR_REF, 32'd125000000, 1'b0);
    rd(`SCS_ADDR_REF, 32'd125000000, 1'b0);
    wr(`SCS_ADDR_REF, 32'd1000000, 1'b0);
    wr(`SCS_ADDR_RATE, 32'd100000000, 1'b0);
    rd(`SCS_ADDR_RATE, 32'd3996094, 1'b0);
    settle();
    chk(32'(clk_ctrl.pll_mult), 32'd1023);
    wr(`SCS_ADDR_REF, 32'd10000000, 1'b0);
    wr(`SCS_ADDR_RATE, 32'd25000000, 1'b0);
    rd(`SCS_ADDR_RATE, 32'd25000000, 1'b0);
    settle();
    chk(32'(clk_ctrl.pll_mult), 32'd640);
    chk(32'(clk_ctrl.pll_bypass), 32'h0);
    chk(32'(clk_ctrl.pll_ref_ext), 32'h1);
  endtask : t_pll

  task automatic t_term;
    wr(`SCS_ADDR_TERM, 32'h1, 1'b0);
    settle();
    chk(32'(term_50_on), 32'h1);
    wr(`SCS_ADDR_MODE, 32'h2, 1'b0);
    settle();
    chk(32'(term_50_on), 32'h0);
    rd(`SCS_ADDR_TERM, 32'h1, 1'b0);
    wr(`SCS_ADDR_TERM, 32'h0, 1'b0);
    wr(`SCS_ADDR_MODE, 32'h20, 1'b0);
    settle();
    chk(32'(term_50_on), 32'h0);
  endtask : t_term

  initial begin
    presetn = 1'b0;
    fitted = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    t_reset();
    t_osc1();
    t_clkout();
    t_osc2();
    t_pll();
    t_term();
    report_and_stop();
  end
endmodule : tb_top

`default_nettype wire
